// ### inc/hca_defs.svh
// Bit positions, widths and counts of the command/address capture block.
// Assumes inclusion by every file that uses its macros; definitions only.
`ifndef HCA_DEFS_SVH
`define HCA_DEFS_SVH

`define HCA_CA_W 48
`define HCA_DIR_BIT 47
`define HCA_SPACE_BIT 46
`define HCA_BURST_BIT 45
`define HCA_ROW_MSB 44
`define HCA_ROW_LSB 16
`define HCA_ROW_W 29
`define HCA_RSV_MSB 15
`define HCA_RSV_LSB 3
`define HCA_COL_MSB 2
`define HCA_COL_W 3
`define HCA_ADDR_W 32
`define HCA_WORD_W 16
`define HCA_BYTE_W 8
`define HCA_WORD_SHIFT_W 32
`define HCA_CNT_ROW_DONE 2'h1
`define HCA_CNT_CA_DONE 2'h2
`define HCA_CNT_W 2
`define HCA_LAT_W 4
`define HCA_LAT_DEFAULT 6
`define HCA_BUF_DEPTH_DEFAULT 4

`endif

// ### inc/hca_pkg.sv
// Shared types of the command/address capture block.
// Assumes nothing beyond a SystemVerilog compiler.
package hca_pkg;

    typedef enum logic [1:0] {
        HCA_PH_CA = 2'b00,
        HCA_PH_LAT = 2'b01,
        HCA_PH_DATA = 2'b10
    } hca_phase_t;

    typedef enum logic [0:0] {
        HCA_CS_IDLE = 1'b0,
        HCA_CS_RUN = 1'b1
    } hca_core_st_t;

endpackage

// ### testbench/hca_host_model.sv
// Host controller model: frames, link clock, command/address and data bytes.
// Assumes the bench fills wd and wm, then reads lat_hi, rd and rs after xfer.
`timescale 1ns/1ns
module hca_host_model (
    output logic bus_clock_o,
    output logic bus_clock_inverted_o,
    output logic chip_select_n_o,
    output logic [7:0] dq_o,
    output logic read_write_strobe_o,
    input wire logic [7:0] dq_i,
    input wire logic read_write_strobe_i
);
    logic [15:0] wd [8];
    logic [1:0] wm [8];
    logic [15:0] rd [8];
    logic [1:0] rs [8];
    logic lat_hi;
    initial begin
        bus_clock_o = 1'b0;
        bus_clock_inverted_o = 1'b1;
        chip_select_n_o = 1'b1;
        dq_o = 8'h00;
        read_write_strobe_o = 1'b0;
        lat_hi = 1'b0;
    end
    // Byte set 40 ns before the edge, lanes sampled 40 ns after it
    task automatic half(input logic [7:0] b, input logic m, output logic [7:0] q,
        output logic s);
        dq_o = b;
        read_write_strobe_o = m;
        #40;
        bus_clock_o = ~bus_clock_o;
        bus_clock_inverted_o = ~bus_clock_o;
        #40;
        q = dq_i;
        s = read_write_strobe_i;
    endtask
    task automatic xfer(input logic [47:0] ca, input int lat, input int nw);
        logic [7:0] q;
        logic s;
        int i;
        chip_select_n_o = 1'b0;
        #40;
        for (i = 5; i >= 0; i--) begin
            half(ca[i*8+:8], 1'b0, q, s);
            if (i == 4) lat_hi = s;
        end
        for (i = 0; i < 2 * lat * (lat_hi ? 2 : 1); i++) half(~dq_o, 1'b0, q, s);
        for (i = 0; i < nw; i++) begin
            if (ca[47]) begin
                half(~dq_o, 1'b0, rd[i][15:8], rs[i][1]);
                half(~dq_o, 1'b0, rd[i][7:0], rs[i][0]);
            end else begin
                half(wd[i][15:8], wm[i][1], q, s);
                half(wd[i][7:0], wm[i][0], q, s);
            end
        end
        dq_o = ~dq_o;
        chip_select_n_o = 1'b1;
        #400;
    endtask
endmodule

// ### testbench/hca_top_asserts.sv
// Concurrent checks on the ports of the command/address capture block.
// Assumes binding to hca_top; all checks run on the core clock.
`timescale 1ns/1ns
`include "hca_defs.svh"
module hca_top_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic chip_select_n_i,
    input wire logic dq_oe_b_o,
    input wire logic read_write_strobe_oe_b_o,
    input wire logic ca_valid_o,
    input wire logic dir_read_o,
    input wire logic space_reg_o,
    input wire logic burst_linear_o,
    input wire logic [`HCA_ROW_W-1:0] row_addr_o,
    input wire logic [`HCA_COL_W-1:0] col_addr_o,
    input wire logic access_start_o,
    input wire logic [`HCA_ROW_W-1:0] access_row_o,
    input wire logic rd_req_o,
    input wire logic rd_ack_i,
    input wire logic [`HCA_ADDR_W-1:0] rd_addr_o,
    input wire logic wr_valid_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_cs_high_hiz: assert property (chip_select_n_i |-> dq_oe_b_o && read_write_strobe_oe_b_o)
        else $error("lanes driven while deselected");
    a_write_no_drive: assert property (ca_valid_o && !dir_read_o |-> dq_oe_b_o)
        else $error("data lanes driven in a write");
    a_valid_in_frame: assert property ($rose(ca_valid_o) |-> !chip_select_n_i)
        else $error("decode outside a frame");
    a_start_pulse: assert property (access_start_o |=> !access_start_o)
        else $error("access start longer than one cycle");
    a_start_before: assert property (access_start_o |-> !ca_valid_o)
        else $error("access start after full decode");
    a_row_match: assert property ($rose(ca_valid_o) |-> access_row_o == row_addr_o)
        else $error("access row differs from decoded row");
    a_decode_hold: assert property (ca_valid_o && $past(ca_valid_o) |->
        $stable({dir_read_o, space_reg_o, burst_linear_o, row_addr_o, col_addr_o}))
        else $error("decoded fields moved while valid");
    a_rd_dir: assert property (rd_req_o |-> dir_read_o)
        else $error("read request in a write");
    a_rd_hold: assert property (rd_req_o && !rd_ack_i |=> $stable(rd_addr_o))
        else $error("read address moved before ack");
    a_wr_pulse: assert property (wr_valid_o |-> !dir_read_o ##1 !wr_valid_o)
        else $error("bad write word pulse");

    c_read: cover property ($rose(ca_valid_o) && dir_read_o);
    c_reg_write: cover property (wr_valid_o && space_reg_o);
    c_abort: cover property ($rose(chip_select_n_i) && ca_valid_o);
endmodule

bind hca_top hca_top_asserts u_chk (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .chip_select_n_i(chip_select_n_i),
    .dq_oe_b_o(dq_oe_b_o),
    .read_write_strobe_oe_b_o(read_write_strobe_oe_b_o),
    .ca_valid_o(ca_valid_o),
    .dir_read_o(dir_read_o),
    .space_reg_o(space_reg_o),
    .burst_linear_o(burst_linear_o),
    .row_addr_o(row_addr_o),
    .col_addr_o(col_addr_o),
    .access_start_o(access_start_o),
    .access_row_o(access_row_o),
    .rd_req_o(rd_req_o),
    .rd_ack_i(rd_ack_i),
    .rd_addr_o(rd_addr_o),
    .wr_valid_o(wr_valid_o)
);

// ### testbench/hca_top_test.sv
// Self-checking bench of the command/address capture block.
// Assumes the design, the checker bind and the host model are compiled first.
`timescale 1ns/1ns
`include "hca_defs.svh"
module hca_top_test;
    localparam int LAT = 2;
    // Row bits the array actually decodes; the host zeroes the rest
    localparam logic [28:0] ROW_USED = 29'h1FFFFFFF;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic bus_clock_i, bus_clock_inverted_i, chip_select_n_i, read_write_strobe_i, read_write_strobe_o, h_read_write_strobe;
    logic [7:0] dq_i, dq_o, h_dq;
    logic dq_oe_b_o, read_write_strobe_oe_b_o, xfer_active_o, ca_valid_o, dir_read_o, space_reg_o;
    logic burst_linear_o, access_start_o, rd_req_o, wr_valid_o;
    logic refresh_pending_i = 1'b0;
    logic rd_ack_i = 1'b0;
    logic [`HCA_ROW_W-1:0] row_addr_o, access_row_o;
    logic [`HCA_COL_W-1:0] col_addr_o;
    logic [31:0] rd_addr_o, wr_addr_o;
    logic [15:0] rd_data_i, wr_data_o;
    logic [1:0] wr_mask_o;
    logic [15:0] seed = 16'h0010;
    logic [15:0] ack_s = 16'h0010;
    logic [49:0] exp_wq [$];
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;

    always #2 ref_clk_i = ~ref_clk_i;
    assign dq_i = dq_oe_b_o ? h_dq : dq_o;
    assign read_write_strobe_i = read_write_strobe_oe_b_o ? h_read_write_strobe : read_write_strobe_o;
    assign rd_data_i = rdat(rd_addr_o);

    hca_host_model u_host (.bus_clock_o(bus_clock_i), .bus_clock_inverted_o(bus_clock_inverted_i),
        .chip_select_n_o(chip_select_n_i), .dq_o(h_dq), .read_write_strobe_o(h_read_write_strobe), .dq_i(dq_i),
        .read_write_strobe_i(read_write_strobe_i));

    hca_top #(.LAT_CYC(LAT)) i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .bus_clock_i(bus_clock_i), .bus_clock_inverted_i(bus_clock_inverted_i),
        .chip_select_n_i(chip_select_n_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_b_o(dq_oe_b_o),
        .read_write_strobe_i(read_write_strobe_i), .read_write_strobe_o(read_write_strobe_o), .read_write_strobe_oe_b_o(read_write_strobe_oe_b_o),
        .refresh_pending_i(refresh_pending_i), .xfer_active_o(xfer_active_o),
        .ca_valid_o(ca_valid_o), .dir_read_o(dir_read_o), .space_reg_o(space_reg_o),
        .burst_linear_o(burst_linear_o), .row_addr_o(row_addr_o), .col_addr_o(col_addr_o),
        .access_start_o(access_start_o), .access_row_o(access_row_o), .rd_req_o(rd_req_o),
        .rd_addr_o(rd_addr_o), .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i),
        .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .wr_mask_o(wr_mask_o));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] rdat(input logic [31:0] a);
        return {a[7:0] ^ 8'hC3, a[15:8] ^ a[23:16]};
    endfunction
    function automatic logic [31:0] nxt(input logic [31:0] a, input logic lin);
        return lin ? a + 32'h1 : {a[31:3], a[2:0] + 3'h1};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Random ack stalls on the read port, plus the run limit
    always @(posedge ref_clk_i) begin
        #1;
        ack_s = lfsr(ack_s);
        rd_ack_i = ack_s[0];
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    always @(negedge ref_clk_i) begin
        if (wr_valid_o === 1'b1) check({wr_addr_o, wr_data_o, wr_mask_o}, exp_wq.pop_front());
        if (access_start_o === 1'b1) check(xfer_active_o, 1'b1);
    end

    task automatic run_frame(input logic rdir, input logic sp, input logic lin, input int nw,
        input logic refr);
        logic [47:0] ca;
        logic [31:0] a;
        logic [63:0] dec;
        int i;
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            ca = {ca[31:0], seed};
        end
        ca[47:45] = {rdir, sp, lin};
        ca[44:16] = ca[44:16] & ROW_USED;
        a = {ca[44:16], ca[2:0]};
        for (i = 0; i < nw; i++) begin
            seed = lfsr(seed);
            u_host.wd[i] = seed;
            u_host.wm[i] = seed[9:8];
            if (!rdir) exp_wq.push_back({a, seed, seed[9:8]});
            a = nxt(a, lin);
        end
        @(posedge ref_clk_i);
        #1;
        refresh_pending_i = refr;
        repeat (8) @(posedge ref_clk_i);
        #(seed[3:0] + 1);
        u_host.xfer(ca, LAT, nw);
        check({xfer_active_o, ca_valid_o}, 2'b00);
        check(u_host.lat_hi, refr);
        dec = {dir_read_o, space_reg_o, burst_linear_o, row_addr_o, col_addr_o, access_row_o};
        check(dec[63:61], ca[47:45]);
        check(dec[60:29], {ca[44:16], ca[2:0]});
        check(dec[28:0], ca[44:16]);
        a = {ca[44:16], ca[2:0]};
        for (i = 0; i < nw && rdir; i++) begin
            check(u_host.rd[i], rdat(a));
            check(u_host.rs[i], 2'b10);
            a = nxt(a, lin);
        end
        check(exp_wq.size(), 0);
        $display("frame dir %b space %b linear %b words %0d done", rdir, sp, lin, nw);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        for (k = 0; k < 8; k++) run_frame(k[2], k[1], k[0], 8, k[0] ^ k[2]);
        for (k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            run_frame(seed[0], seed[1], seed[2], int'(seed[6:4]), seed[3]);
        end
        print_verdict();
    end
endmodule

// ### verilog/hca_rise_det.sv
// Brings a level from another clock in and pulses once on its rise.
// Assumes the level stays high for at least four clk_i cycles.
`timescale 1ns/1ns
module hca_rise_det (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic lvl_i,
    output logic pulse_o
);
    typedef struct packed {
        logic last;
        logic pulse;
    } hca_rise_st_t;

    hca_rise_st_t q, d;
    logic lvl_s;

    hca_sync3 #(.W(1), .RST_VAL(1'b0)) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(lvl_i),
        .q_o(lvl_s)
    );

    always_comb begin
        d = q;
        d.last = lvl_s;
        d.pulse = lvl_s & ~q.last;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pulse_o = q.pulse;
endmodule

// ### verilog/hca_sync3.sv
// Three-flop synchroniser for a bus of levels.
// Assumes each bit changes slowly against clk_i, or the bus is gray coded.
`timescale 1ns/1ns
module hca_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } hca_sync_st_t;

    hca_sync_st_t q, d;

    always_comb begin
        d = q;
        d.s1 = d_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.val[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, val: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign q_o = q.val;
endmodule

// ### verilog/hca_top.sv
// Command/address capture, decode and data byte placement of a byte-wide DDR slave.
// Assumes bus_clock_i stops outside frames and chip_select_n_i frames every transfer.
//
// Overview of operation
// (RULE_01) Host opens a frame by lowering chip select while bus clock is idle low.
// (RULE_02) First three clock cycles carry three command/address words, six DDR edges.
// (RULE_03) Command/address bytes arrive most significant first, bit 7 on lane 7.
// (RULE_04) Bit 47 set means read, clear means write.
// (RULE_05) Bit 46 clear targets memory array, set targets register space.
// (RULE_06) Bit 45 clear requests wrapped burst, set requests linear burst.
// (RULE_07) Bits 44 to 16 form word address bits 31 to 3.
// (RULE_08) Host zeroes unused upper row bits.
// (RULE_09) Bits 15 to 3 are reserved and ignored by the device.
// (RULE_10) Bits 2 to 0 give starting word within the half-page.
// (RULE_11) Upper column picks an eight word half-page, lower column the word.
// (RULE_12) Initial access timing starts when row and half-page bits are captured.
// (RULE_13) Linear reads run on across successive half-pages without a gap.
// (RULE_14) Memory words come back in exactly the byte order they were written.
// (RULE_15) Register space data is placed big-endian.
// (RULE_16) During reads the strobe is driven with data edges aligned to it.
// (RULE_17) Data moves in whole 16-bit words only, never a lone byte.
// (RULE_18) One word per clock; first byte while strobe high, second while low.
// (RULE_19) Host centres command/address bytes on the clock edges.
// (RULE_20) Strobe high during command/address asks for extra initial latency.
// (RULE_21) Chip select rising ends the frame and abandons any burst.
// (RULE_22) All 48 bits are shifted in and decoded only after the sixth edge; the code captures the row and starts access after the fourth edge.
`timescale 1ns/1ns
`include "hca_defs.svh"
module hca_top #(
    parameter int LAT_CYC = `HCA_LAT_DEFAULT,
    parameter int BUF_DEPTH = `HCA_BUF_DEPTH_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic bus_clock_i,
    input wire logic bus_clock_inverted_i,
    input wire logic chip_select_n_i,
    input wire logic [`HCA_BYTE_W-1:0] dq_i,
    output logic [`HCA_BYTE_W-1:0] dq_o,
    output logic dq_oe_b_o,
    input wire logic read_write_strobe_i,
    output logic read_write_strobe_o,
    output logic read_write_strobe_oe_b_o,
    input wire logic refresh_pending_i,
    output logic xfer_active_o,
    output logic ca_valid_o,
    output logic dir_read_o,
    output logic space_reg_o,
    output logic burst_linear_o,
    output logic [`HCA_ROW_W-1:0] row_addr_o,
    output logic [`HCA_COL_W-1:0] col_addr_o,
    output logic access_start_o,
    output logic [`HCA_ROW_W-1:0] access_row_o,
    output logic rd_req_o,
    output logic [`HCA_ADDR_W-1:0] rd_addr_o,
    input wire logic rd_ack_i,
    input wire logic [`HCA_WORD_W-1:0] rd_data_i,
    output logic wr_valid_o,
    output logic [`HCA_ADDR_W-1:0] wr_addr_o,
    output logic [`HCA_WORD_W-1:0] wr_data_o,
    output logic [1:0] wr_mask_o
);
    localparam int IDX_W = $clog2(BUF_DEPTH);
    localparam int PTR_W = IDX_W + 1;
    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(BUF_DEPTH);
    localparam logic [`HCA_LAT_W-1:0] LAT_LOAD = `HCA_LAT_W'(LAT_CYC - 1);

    generate
        if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("BUF_DEPTH must be a power of two, at least 2");
        end
        if (LAT_CYC < 2 || LAT_CYC > 16) begin : g_bad_lat
            $error("LAT_CYC must lie between 2 and 16");
        end
    endgenerate

    // Link state on the falling edge of the bus clock
    typedef struct packed {
        hca_pkg::hca_phase_t ph;
        logic [`HCA_CA_W-1:0] ca;
        logic [`HCA_CNT_W-1:0] cnt;
        logic [`HCA_LAT_W-1:0] lat;
        logic ext;
        logic rd;
        logic row_done;
        logic ca_done;
        logic [`HCA_ROW_W-1:0] row;
        logic [PTR_W-1:0] idx;
        logic [PTR_W-1:0] idx_gray;
        logic [`HCA_BYTE_W-1:0] dq_b;
    } hca_lneg_t;

    // Link state on the rising edge of the bus clock
    typedef struct packed {
        logic [`HCA_BYTE_W-1:0] rise_byte;
        logic rise_mask;
        logic [`HCA_BYTE_W-1:0] dq_a;
        logic st_hi;
    } hca_lpos_t;

    // Core state on the reference clock
    typedef struct packed {
        hca_pkg::hca_core_st_t st;
        logic active;
        logic lat_req;
        logic ca_valid;
        logic dir;
        logic space;
        logic burst;
        logic [`HCA_ROW_W-1:0] row;
        logic [`HCA_COL_W-1:0] col;
        logic acc_start;
        logic [`HCA_ROW_W-1:0] acc_row;
        logic rd_req;
        logic pend;
        logic [`HCA_ADDR_W-1:0] addr;
        logic [PTR_W-1:0] fill;
        logic [PTR_W-1:0] drain;
        logic wr_valid;
        logic [`HCA_ADDR_W-1:0] wr_addr;
        logic [`HCA_WORD_W-1:0] wr_data;
        logic [1:0] wr_mask;
    } hca_core_t;

    hca_lneg_t ln_q, ln_d;
    hca_lpos_t lp_q, lp_d;
    hca_core_t c_q, c_d;

    logic [`HCA_WORD_W-1:0] rbuf [BUF_DEPTH];
    logic [`HCA_WORD_W+1:0] wbuf [BUF_DEPTH];

    logic lnk_rst_b;
    logic ext_s;
    logic cs_s;
    logic row_pulse;
    logic ca_pulse;
    logic [PTR_W-1:0] cons_gray;
    logic [PTR_W-1:0] cons_bin;
    logic [`HCA_CA_W-1:0] ca_nx;
    logic [`HCA_WORD_W-1:0] rd_word;
    logic [`HCA_WORD_W+1:0] wr_word;
    logic rd_data_phase;

    // Link logic is cleared whenever the frame is closed
    assign lnk_rst_b = rst_b_i & ~chip_select_n_i; // RULE_21

    // Extra latency request crosses into the link domain
    hca_sync3 #(.W(1), .RST_VAL(1'b0)) u_ext_sync (
        .clk_i(bus_clock_i),
        .rst_b_i(lnk_rst_b),
        .d_i(c_q.lat_req),
        .q_o(ext_s)
    );

    // Link side levels and pointer cross into the core domain
    hca_sync3 #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(chip_select_n_i),
        .q_o(cs_s)
    );

    hca_rise_det u_row_det (
        .clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .lvl_i(ln_q.row_done),
        .pulse_o(row_pulse)
    );

    hca_rise_det u_ca_det (
        .clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .lvl_i(ln_q.ca_done),
        .pulse_o(ca_pulse)
    );

    hca_sync3 #(.W(PTR_W), .RST_VAL('0)) u_ptr_sync (
        .clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(ln_q.idx_gray),
        .q_o(cons_gray)
    );

    always_comb begin
        cons_bin = '0;
        for (int i = PTR_W - 1; i >= 0; i--) begin
            if (i == PTR_W - 1) begin
                cons_bin[i] = cons_gray[i];
            end else begin
                cons_bin[i] = cons_bin[i + 1] ^ cons_gray[i];
            end
        end
    end

    // Next word address of a burst
    function automatic logic [`HCA_ADDR_W-1:0] hca_next_addr(
        input logic [`HCA_ADDR_W-1:0] a,
        input logic linear
    );
        logic [`HCA_ADDR_W-1:0] r;
        r = a;
        if (linear) begin
            r = a + `HCA_ADDR_W'(1); // RULE_13
        end else begin
            r[`HCA_COL_W-1:0] = a[`HCA_COL_W-1:0] + `HCA_COL_W'(1); // RULE_11
        end
        return r;
    endfunction

    // Byte lanes straight into the shift, most significant byte first
    assign ca_nx = {ln_q.ca[`HCA_WORD_SHIFT_W-1:0], lp_q.rise_byte, dq_i}; // RULE_03
    assign rd_word = rbuf[ln_q.idx[IDX_W-1:0]];
    assign rd_data_phase = (ln_q.ph == hca_pkg::HCA_PH_DATA) && ln_q.rd;

    // Rising edge: first byte in, first read byte out
    always_comb begin
        lp_d = lp_q;
        lp_d.rise_byte = dq_i;
        lp_d.rise_mask = read_write_strobe_i;
        lp_d.st_hi = 1'b0;
        if (rd_data_phase) begin
            lp_d.dq_a = rd_word[`HCA_WORD_W-1:`HCA_BYTE_W]; // RULE_18
            lp_d.st_hi = 1'b1; // RULE_16
        end
    end

    always_ff @(posedge bus_clock_i or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            lp_q <= '0;
        end else begin
            lp_q <= lp_d;
        end
    end

    // Falling edge: completes each word
    always_comb begin
        ln_d = ln_q;
        case (ln_q.ph)
            hca_pkg::HCA_PH_CA: begin
                ln_d.ca = ca_nx; // RULE_22
                ln_d.cnt = ln_q.cnt + `HCA_CNT_W'(1); // RULE_02
                if (ln_q.cnt == `HCA_CNT_ROW_DONE) begin
                    ln_d.row = ca_nx[`HCA_ROW_W-1:0]; // RULE_12
                    ln_d.row_done = 1'b1;
                end
                if (ln_q.cnt == `HCA_CNT_CA_DONE) begin
                    ln_d.ca_done = 1'b1; // RULE_22
                    ln_d.rd = ca_nx[`HCA_DIR_BIT]; // RULE_04
                    ln_d.ph = hca_pkg::HCA_PH_LAT;
                    ln_d.lat = LAT_LOAD;
                end
            end
            hca_pkg::HCA_PH_LAT: begin
                if (ln_q.lat != '0) begin
                    ln_d.lat = ln_q.lat - `HCA_LAT_W'(1);
                end else if (ext_s && !ln_q.ext) begin
                    ln_d.ext = 1'b1; // RULE_20
                    ln_d.lat = LAT_LOAD;
                end else begin
                    ln_d.ph = hca_pkg::HCA_PH_DATA;
                end
            end
            hca_pkg::HCA_PH_DATA: begin
                if (ln_q.rd) begin
                    ln_d.dq_b = rd_word[`HCA_BYTE_W-1:0]; // RULE_18
                end
                ln_d.idx = ln_q.idx + PTR_W'(1); // RULE_17
                ln_d.idx_gray = ln_d.idx ^ (ln_d.idx >> 1);
            end
            default: begin
                ln_d.ph = hca_pkg::HCA_PH_CA;
            end
        endcase
    end

    always_ff @(negedge bus_clock_i or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            ln_q <= '{ph: hca_pkg::HCA_PH_CA, default: '0};
        end else begin
            ln_q <= ln_d;
        end
    end

    // Write words kept whole, bytes in arrival order with their masks
    always_ff @(negedge bus_clock_i) begin
        if (ln_q.ph == hca_pkg::HCA_PH_DATA && !ln_q.rd) begin
            wbuf[ln_q.idx[IDX_W-1:0]] <= {lp_q.rise_byte, dq_i, lp_q.rise_mask, read_write_strobe_i}; // RULE_17
        end
    end

    assign wr_word = wbuf[c_q.drain[IDX_W-1:0]];

    // Core side: decode, prefetch and drain
    always_comb begin
        c_d = c_q;
        c_d.acc_start = 1'b0;
        c_d.rd_req = 1'b0;
        c_d.wr_valid = 1'b0;
        if (cs_s) begin
            c_d.st = hca_pkg::HCA_CS_IDLE; // RULE_21
            c_d.active = 1'b0;
            c_d.pend = 1'b0;
            c_d.ca_valid = 1'b0;
            c_d.lat_req = refresh_pending_i; // RULE_20
        end else begin
            c_d.active = 1'b1;
            if (row_pulse) begin
                c_d.acc_start = 1'b1; // RULE_12
                c_d.acc_row = ln_q.row;
            end
            if (ca_pulse) begin
                c_d.st = hca_pkg::HCA_CS_RUN;
                c_d.ca_valid = 1'b1;
                c_d.dir = ln_q.ca[`HCA_DIR_BIT]; // RULE_04
                c_d.space = ln_q.ca[`HCA_SPACE_BIT]; // RULE_05
                c_d.burst = ln_q.ca[`HCA_BURST_BIT]; // RULE_06
                c_d.row = ln_q.ca[`HCA_ROW_MSB:`HCA_ROW_LSB]; // RULE_07
                c_d.col = ln_q.ca[`HCA_COL_MSB:0]; // RULE_10
                // Bits between the two address fields are dropped
                c_d.addr = {ln_q.ca[`HCA_ROW_MSB:`HCA_ROW_LSB], ln_q.ca[`HCA_COL_MSB:0]}; // RULE_09
                c_d.fill = '0;
                c_d.drain = '0;
                c_d.pend = 1'b0;
            end else if (c_q.st == hca_pkg::HCA_CS_RUN) begin
                if (c_q.dir) begin
                    if (c_q.pend) begin
                        if (rd_ack_i) begin
                            c_d.pend = 1'b0;
                            c_d.fill = c_q.fill + PTR_W'(1);
                            c_d.addr = hca_next_addr(c_q.addr, c_q.burst); // RULE_13
                        end
                    end else if (PTR_W'(c_q.fill - cons_bin) < DEPTH_P) begin
                        c_d.rd_req = 1'b1;
                        c_d.pend = 1'b1;
                    end
                end else if (c_q.drain != cons_bin) begin
                    c_d.wr_valid = 1'b1;
                    c_d.wr_addr = c_q.addr;
                    // Memory keeps arrival order; registers read A as high byte
                    c_d.wr_data = wr_word[`HCA_WORD_W+1:2]; // RULE_14 RULE_15
                    c_d.wr_mask = wr_word[1:0];
                    c_d.drain = c_q.drain + PTR_W'(1);
                    c_d.addr = hca_next_addr(c_q.addr, c_q.burst);
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            c_q <= '{st: hca_pkg::HCA_CS_IDLE, default: '0};
        end else begin
            c_q <= c_d;
        end
    end

    // Fetched words stored unchanged: high byte goes out first
    always_ff @(posedge ref_clk_i) begin
        if (c_q.st == hca_pkg::HCA_CS_RUN && c_q.pend && rd_ack_i && !cs_s) begin
            rbuf[c_q.fill[IDX_W-1:0]] <= rd_data_i; // RULE_14 RULE_15
        end
    end

    // DDR pins: byte A while clock high, byte B while low
    assign dq_o = bus_clock_i ? lp_q.dq_a : ln_q.dq_b; // RULE_18
    assign dq_oe_b_o = chip_select_n_i | ~rd_data_phase;
    assign read_write_strobe_o = rd_data_phase ? (bus_clock_i & lp_q.st_hi) : c_q.lat_req; // RULE_16 RULE_20
    assign read_write_strobe_oe_b_o = chip_select_n_i | ((ln_q.ph != hca_pkg::HCA_PH_CA) & ~ln_q.rd);

    assign xfer_active_o = c_q.active;
    assign ca_valid_o = c_q.ca_valid;
    assign dir_read_o = c_q.dir;
    assign space_reg_o = c_q.space;
    assign burst_linear_o = c_q.burst;
    assign row_addr_o = c_q.row;
    assign col_addr_o = c_q.col;
    assign access_start_o = c_q.acc_start;
    assign access_row_o = c_q.acc_row;
    assign rd_req_o = c_q.rd_req;
    assign rd_addr_o = c_q.addr;
    assign wr_valid_o = c_q.wr_valid;
    assign wr_addr_o = c_q.wr_addr;
    assign wr_data_o = c_q.wr_data;
    assign wr_mask_o = c_q.wr_mask;
endmodule
